// ---- bench/dfa_mem_model.sv ----
// ****************************************************************
// Memory controller stand-in
// ****************************************************************
module dfa_mem_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Request and pacing
  input wire dfa_pkg::dfa_mem_req_t mem_req_in,
  input wire logic slow_in,
  // Answer
  output dfa_pkg::dfa_mem_rsp_t mem_rsp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;
  // One quadword per grant; slow mode idles so the request must hold
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mem_rsp_out <= '0;
      wait_r <= 2'h0;
    end
    else if (mem_rsp_out.ack)
    begin
      mem_rsp_out <= '0;
      wait_r <= slow_in ? 2'h3 : 2'h0;
    end
    else if (wait_r != 2'h0)
      wait_r <= wait_r - 2'h1;
    else
      mem_rsp_out <= {mem_req_in.req, mem_req_in.req};
  end
endmodule : dfa_mem_model

// ---- bench/dfa_top_props.sv ----
// ****************************************************************
// Port checker for the fetch address block
// ****************************************************************
module dfa_top_props #(
  parameter int QW_W = 9,
  parameter int CB_LEN_W = 7
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Register bus
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // Timing events
  input wire logic frame_start_in,
  input wire logic line_start_in,
  input wire logic cb_word_in,
  // Outputs and memory answer
  input wire logic [31:0] vid_addr_out,
  input wire logic [31:0] vid_limit_out,
  input wire logic cb_overflow_out,
  input wire dfa_pkg::dfa_mem_rsp_t mem_rsp_in,
  input wire dfa_pkg::dfa_mem_req_t mem_req_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  // A taken request gets exactly one short answer
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  chk_one_wait: assert property (s_req |=> s_ans)
    else $error("bus answer late or too long");
  chk_wait_rest: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
    else $error("waitrequest low without request");
  // Limit stays within one megabyte of 64-byte segments
  chk_vid_limit: assert property ($stable(vid_addr_out) [*2] |->
    ((vid_limit_out - vid_addr_out) <= 32'h0010_0000) &&
    (((vid_limit_out - vid_addr_out) & 32'h0000_003f) == 32'h0000_0000))
    else $error("video limit out of range");
  // Fetch only after a line start, held until granted
  chk_req_start: assert property ($rose(mem_req_out.req) |->
    $past(line_start_in) && !$past(frame_start_in)) else $error("fetch without line start");
  chk_req_hold: assert property (mem_req_out.req && !mem_rsp_in.ack && !frame_start_in |=>
    mem_req_out.req && $stable(mem_req_out.addr)) else $error("fetch request dropped");
  chk_addr_step: assert property (mem_req_out.req && mem_rsp_in.ack && !frame_start_in |=>
    !mem_req_out.req || mem_req_out.addr == $past(mem_req_out.addr) + 32'h0000_0008)
    else $error("fetch address step wrong");
  // Overflow follows a word and lasts to the next line
  chk_ovf_cause: assert property ($rose(cb_overflow_out) |-> $past(cb_word_in))
    else $error("overflow without word");
  chk_ovf_hold: assert property (cb_overflow_out && !line_start_in && !frame_start_in |=>
    cb_overflow_out) else $error("overflow dropped early");
  chk_ovf_clear: assert property ((line_start_in || frame_start_in) && !cb_word_in |=>
    !cb_overflow_out) else $error("overflow not cleared");
endmodule : dfa_top_props

bind dfa_top dfa_top_props #(.QW_W(QW_W), .CB_LEN_W(CB_LEN_W)) chk_u (.*);

// ---- bench/display_fetch_address_gen_tb.sv ----
`include "dfa_cfg.svh"
// ****************************************************************
// Bench for the fetch address block
// ****************************************************************
module display_fetch_address_gen_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [15:0] avs_address_in = 16'h0000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic frame_start_in = 1'b0;
  logic line_start_in = 1'b0;
  logic cb_word_in = 1'b0;
  logic slow = 1'b0;
  logic [21:0] fb_start_in = 22'h0;
  logic [21:0] cb_start_in = 22'h0;
  logic [31:0] base = 32'h0000_0000;
  logic [31:0] rdata, vid, pitch, size, exp_addr;
  logic [31:0] avs_readdata_out, vid_addr_out, vid_limit_out, cb_line_addr_out;
  logic avs_waitrequest_out, cb_overflow_out, irq_out;
  dfa_pkg::dfa_mem_req_t mem_req;
  dfa_pkg::dfa_mem_rsp_t mem_rsp;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int acks, ql, cl, fb, cb, p, c;

  always #50 clock_in = ~clock_in;

  dfa_top dut_u (.avs_byteenable_in(4'hf), .qw_used_in(1'b0), .graphics_memory_base_in(base),
    .mem_rsp_in(mem_rsp), .mem_req_out(mem_req), .*);

  dfa_mem_model mem_u (.clock_in(clock_in), .arst_n_in(arst_n_in), .mem_req_in(mem_req),
    .slow_in(slow), .mem_rsp_out(mem_rsp));

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk

  task end_sim;
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Request held until waitrequest is sampled low
  task bus(input logic [15:0] a, input logic wr, input logic [31:0] d);
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    do
      @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0);
    rdata = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus

  task pulse(input logic fr, input logic ln, input logic cw);
    @(posedge clock_in);
    frame_start_in <= fr;
    line_start_in <= ln;
    cb_word_in <= cw;
    @(posedge clock_in);
    frame_start_in <= 1'b0;
    line_start_in <= 1'b0;
    cb_word_in <= 1'b0;
  endtask : pulse

  function automatic logic [31:0] lim(input logic [31:0] a, input logic [13:0] s);
    logic [31:0] b;
    b = {12'h000, s, 6'h00};
    return a + ((b > 32'h0010_0000) ? 32'h0010_0000 : b);
  endfunction : lim

  // Hang guard and fetch address tracking per grant
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
    if (mem_req.req === 1'b1 && mem_rsp.ack === 1'b1)
    begin
      chk("fetch address", exp_addr, mem_req.addr);
      exp_addr = exp_addr + 32'h0000_0008;
      acks++;
    end
  end

  initial
  begin
    void'($urandom(32'h4105));
    base = $urandom;
    repeat (20) @(posedge clock_in);
    arst_n_in <= 1'b1;
    // Reserved slot, unmapped access and interrupt
    bus(`DFA_OFF_RSVD, 1'b1, 32'hffff_ffff);
    bus(`DFA_OFF_RSVD, 1'b0, 32'h0);
    chk("reserved slot", 32'h0, rdata);
    bus(16'h8340, 1'b0, 32'h0);
    chk("unmapped read", 32'h0, rdata);
    bus(`DFA_OFF_MASK, 1'b1, 32'h10);
    repeat (2) @(posedge clock_in);
    chk("irq raised", 32'h1, {31'h0, irq_out});
    bus(`DFA_OFF_STATUS, 1'b1, 32'h10);
    repeat (2) @(posedge clock_in);
    chk("irq cleared", 32'h0, {31'h0, irq_out});
    bus(`DFA_OFF_MASK, 1'b1, 32'h0);
    bus(16'h8344, 1'b1, 32'h5);
    bus(`DFA_OFF_STATUS, 1'b0, 32'h0);
    chk("irq masked", 32'h10, (rdata & 32'h10) | {31'h0, irq_out});
    // Random programming with size corners, capacity kept legal
    for (int i = 0; i < 6; i++)
    begin
      vid = $urandom & 32'h003f_fff0;
      pitch = $urandom & 32'h003f_f3ff;
      size = {2'b00, (i == 0) ? 14'h3fff : 14'($urandom), 7'($urandom_range(65)), 9'($urandom)};
      bus(`DFA_OFF_VID_START, 1'b1, vid);
      bus(`DFA_OFF_PITCH, 1'b1, pitch);
      bus(`DFA_OFF_SIZE, 1'b1, size);
      bus(`DFA_OFF_VID_START, 1'b0, 32'h0);
      chk("video start", vid, rdata);
      bus(`DFA_OFF_PITCH, 1'b0, 32'h0);
      chk("line pitch", pitch, rdata);
      bus(`DFA_OFF_SIZE, 1'b0, 32'h0);
      chk("buffer size", size, rdata);
      chk("video address", base + vid, vid_addr_out);
      chk("video limit", lim(base + vid, size[29:16]), vid_limit_out);
    end
    // Two frames of three lines, fetch and pointer walk
    bus(`DFA_OFF_CTRL, 1'b1, 32'h1);
    for (int f = 0; f < 2; f++)
    begin
      fb = $urandom & 32'h003f_ffff;
      cb = $urandom & 32'h003f_fff0;
      fb_start_in <= 22'(fb);
      cb_start_in <= 22'(cb);
      pitch = $urandom & 32'h003f_f3ff;
      p = pitch[9:0];
      c = pitch[21:12];
      ql = (f == 0) ? 1 : $urandom_range(8, 2);
      cl = $urandom_range(6, 2);
      bus(`DFA_OFF_PITCH, 1'b1, pitch);
      bus(`DFA_OFF_SIZE, 1'b1, {16'h0, 7'(cl), 9'(ql)});
      pulse(1'b1, 1'b0, 1'b0);
      for (int l = 0; l < 3; l++)
      begin
        exp_addr = base + ((fb + l * p * 4) & 32'h003f_ffff);
        acks = 0;
        slow <= l[0];
        pulse(1'b0, 1'b1, 1'b0);
        for (int k = 1; k < cl; k++)
          pulse(1'b0, 1'b0, 1'b1);
        repeat (2) @(posedge clock_in);
        chk("no overflow", 32'h0, {31'h0, cb_overflow_out});
        pulse(1'b0, 1'b0, 1'b1);
        repeat (2) @(posedge clock_in);
        chk("overflow", 32'h1, {31'h0, cb_overflow_out});
        while (acks < ql)
          @(posedge clock_in);
        repeat (3) @(posedge clock_in);
        chk("fetch count", ql, acks);
        chk("fetch idle", 32'h0, {31'h0, mem_req.req});
        bus(`DFA_OFF_FB_PTR, 1'b0, 32'h0);
        chk("frame pointer", (fb + (l + 1) * p * 4) & 32'h003f_ffff, rdata);
        bus(`DFA_OFF_CB_PTR, 1'b0, 32'h0);
        chk("compressed pointer", (cb + (l + 1) * c * 4) & 32'h003f_ffff, rdata);
        chk("compressed address", base + rdata, cb_line_addr_out);
      end
    end
    bus(`DFA_OFF_STATUS, 1'b0, 32'h0);
    chk("frame done overflow discard", 32'hf, rdata & 32'hf);
    end_sim();
  end
endmodule : display_fetch_address_gen_tb

// ---- src/dfa_cfg.svh ----
`ifndef DFA_CFG_SVH
`define DFA_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DFA_OFF_VID_START 16'h8320
`define DFA_OFF_PITCH 16'h8324
`define DFA_OFF_SIZE 16'h8328
`define DFA_OFF_RSVD 16'h832c
`define DFA_OFF_CTRL 16'h8350
`define DFA_OFF_STATUS 16'h8354
`define DFA_OFF_MASK 16'h8358
`define DFA_OFF_FB_PTR 16'h835c
`define DFA_OFF_CB_PTR 16'h8360

// ****************************************************************
// Field positions
// ****************************************************************
`define DFA_VID_MSB 21
`define DFA_CB_PITCH_MSB 21
`define DFA_CB_PITCH_LSB 12
`define DFA_FB_PITCH_MSB 9
`define DFA_VSIZE_MSB 29
`define DFA_VSIZE_LSB 16
`define DFA_CB_LEN_MSB 15
`define DFA_CB_LEN_LSB 9
`define DFA_FB_FETCH_MSB 8

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define DFA_RST_REG 32'h0000_0000
`define DFA_MASK_VID 32'h003f_fff0
`define DFA_MASK_PITCH 32'h003f_f3ff
`define DFA_MASK_SIZE 32'h3fff_ffff
`define DFA_MASK_CTRL 32'h0000_0001
`define DFA_MASK_EVT 32'h0000_001f

// ****************************************************************
// Event bits, scaling, limits
// ****************************************************************
`define DFA_EVT_FRAME 0
`define DFA_EVT_FETCH_DONE 1
`define DFA_EVT_CB_OVF 2
`define DFA_EVT_DISCARD 3
`define DFA_EVT_BAD_ADDR 4
`define DFA_SEG_SHIFT 6
`define DFA_QW_BYTES 32'h0000_0008
`define DFA_VID_MAX_BYTES 23'h10_0000

`endif

// ---- src/dfa_fetch_ctl.sv ----
`include "dfa_cfg.svh"

module dfa_fetch_ctl #(
  parameter int QW_W = 9
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Line control
  input wire logic go_in,
  input wire logic [31:0] line_addr_in,
  input wire logic [QW_W-1:0] qw_count_in,
  input wire logic line_end_in,
  input wire logic qw_used_in,
  // Memory side
  input wire dfa_pkg::dfa_mem_rsp_t mem_rsp_in,
  output dfa_pkg::dfa_mem_req_t mem_req_out,
  // Events
  output logic done_out,
  output logic discard_out
);

  initial
  begin
    if (QW_W < 1 || QW_W > 16)
      $error("dfa_fetch_ctl: QW_W out of range");
  end

  dfa_pkg::dfa_fetch_st_t st_r;
  dfa_pkg::dfa_fetch_st_t st_nxt;
  logic [31:0] addr_r;
  logic [QW_W-1:0] left_r;
  logic [QW_W:0] held_r;
  logic done_r;
  logic disc_r;

  // Request handshake decode
  wire logic granted = (st_r == dfa_pkg::DFA_ST_REQ) && mem_rsp_in.ack;
  wire logic last_qw = granted && (left_r == QW_W'(1));
  wire logic held_up = mem_rsp_in.rvalid && !qw_used_in;
  wire logic held_dn = qw_used_in && !mem_rsp_in.rvalid && (held_r != '0);

  // Next state: a zero count fetches nothing
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      dfa_pkg::DFA_ST_IDLE:
        if (go_in && qw_count_in != '0)
          st_nxt = dfa_pkg::DFA_ST_REQ;
      dfa_pkg::DFA_ST_REQ:
        if (last_qw)
          st_nxt = dfa_pkg::DFA_ST_IDLE;
      default:
        st_nxt = dfa_pkg::DFA_ST_IDLE;
    endcase
  end

  // Sequencer, one quadword per grant
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_r <= dfa_pkg::DFA_ST_IDLE;
      addr_r <= '0;
      left_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == dfa_pkg::DFA_ST_IDLE && go_in)
      begin
        addr_r <= line_addr_in;
        left_r <= qw_count_in; // see R8
      end
      else if (granted)
      begin
        addr_r <= addr_r + `DFA_QW_BYTES;
        left_r <= left_r - QW_W'(1);
      end
    end
  end

  // Quadwords fetched but not yet shown; dropped at line end
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      held_r <= '0;
      done_r <= 1'b0;
      disc_r <= 1'b0;
    end
    else
    begin
      done_r <= last_qw;
      disc_r <= line_end_in && (held_r != '0); // see R10
      if (line_end_in)
        held_r <= '0; // see R10
      else if (held_up)
        held_r <= held_r + (QW_W+1)'(1);
      else if (held_dn)
        held_r <= held_r - (QW_W+1)'(1);
    end
  end

  assign mem_req_out.req = (st_r == dfa_pkg::DFA_ST_REQ);
  assign mem_req_out.addr = addr_r;
  assign done_out = done_r;
  assign discard_out = disc_r;

endmodule : dfa_fetch_ctl

// ---- src/dfa_line_ptr.sv ----
`include "dfa_cfg.svh"

module dfa_line_ptr #(
  parameter int PTR_W = 22,
  parameter int PITCH_W = 10
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Frame and line events
  input wire logic reload_in,
  input wire logic step_in,
  // Programmed values
  input wire logic [PTR_W-1:0] start_in,
  input wire logic [PITCH_W-1:0] pitch_in,
  // Running line start
  output logic [PTR_W-1:0] ptr_out
);

  initial
  begin
    if (PITCH_W + 2 > PTR_W)
      $error("dfa_line_ptr: pitch too wide for pointer");
  end

  logic [PTR_W-1:0] ptr_r;
  logic [PTR_W-1:0] ptr_nxt;
  wire logic [PTR_W-1:0] pitch_bytes = PTR_W'({pitch_in, 2'b00});

  // Reload beats stepping so a frame never starts mid-pitch
  assign ptr_nxt = reload_in ? start_in : // see R12
                   step_in ? ptr_r + pitch_bytes : ptr_r; // see R3 see R4

  // Pointer register
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ptr_r <= '0;
    else
      ptr_r <= ptr_nxt;
  end

  assign ptr_out = ptr_r;

endmodule : dfa_line_ptr

// ---- src/dfa_pkg.sv ----
package dfa_pkg;

  // ****************************************************************
  // Fetch sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    DFA_ST_IDLE = 2'b01,
    DFA_ST_REQ = 2'b10
  } dfa_fetch_st_t;

  // Request toward the memory controller
  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } dfa_mem_req_t;

  // Answer from the memory controller
  typedef struct packed {
    logic ack;
    logic rvalid;
  } dfa_mem_rsp_t;

endpackage : dfa_pkg

// ---- src/dfa_top.sv ----
// Function
// R1 - Video start field is a byte offset from graphics memory base.
// R2 - Software writes the low four video start bits as zero.
// R3 - Next compressed line start is previous start plus compressed pitch.
// R4 - Next frame line start is previous start plus frame pitch in doublewords.
// R5 - Video buffer size counts 64-byte segments, one megabyte at most.
// R6 - Compressed line length plus one detects compressed data FIFO overflow.
// R7 - Software never programs compressed line length above 41h.
// R8 - Each display line fetches the programmed number of quadwords.
// R9 - With panning, software programs fetch length to cover any alignment.
// R10 - Surplus fetched data at line end is discarded automatically.
// R11 - Software writes zero to reserved upper register bits.
// R12 - Line pointers reload from start offsets at each frame start.
`include "dfa_cfg.svh"

module dfa_top #(
  parameter int QW_W = 9,
  parameter int CB_LEN_W = 7
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Avalon-MM slave
  input wire logic [15:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Display timing and FIFO events
  input wire logic frame_start_in,
  input wire logic line_start_in,
  input wire logic cb_word_in,
  input wire logic qw_used_in,
  // Start offsets and graphics memory base held elsewhere
  input wire logic [21:0] fb_start_in,
  input wire logic [21:0] cb_start_in,
  input wire logic [31:0] graphics_memory_base_in,
  // Memory controller
  input wire dfa_pkg::dfa_mem_rsp_t mem_rsp_in,
  output dfa_pkg::dfa_mem_req_t mem_req_out,
  // Buffer addresses and overflow flag
  output logic [31:0] vid_addr_out,
  output logic [31:0] vid_limit_out,
  output logic [31:0] cb_line_addr_out,
  output logic cb_overflow_out,
  // Interrupt
  output logic irq_out
);

  initial
  begin
    if (QW_W != `DFA_FB_FETCH_MSB + 1)
      $error("dfa_top: QW_W must match fetch length field");
    if (CB_LEN_W != `DFA_CB_LEN_MSB - `DFA_CB_LEN_LSB + 1)
      $error("dfa_top: CB_LEN_W must match compressed length field");
  end

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] vid_r;
  logic [31:0] pitch_r;
  logic [31:0] size_r;
  logic [31:0] ctrl_r;
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  logic [31:0] mask_r;

  // Request is taken on the edge that sees waitrequest low
  wire logic req = avs_read_in || avs_write_in;
  wire logic wr_take = avs_write_in && !wait_r;
  wire logic rd_sample = avs_read_in && wait_r;

  // One wait state keeps read data straight from a flop
  assign wait_nxt = !(req && wait_r);

  // Address decode
  wire logic hit_vid = (avs_address_in == `DFA_OFF_VID_START);
  wire logic hit_pitch = (avs_address_in == `DFA_OFF_PITCH);
  wire logic hit_size = (avs_address_in == `DFA_OFF_SIZE);
  wire logic hit_rsvd = (avs_address_in == `DFA_OFF_RSVD);
  wire logic hit_ctrl = (avs_address_in == `DFA_OFF_CTRL);
  wire logic hit_status = (avs_address_in == `DFA_OFF_STATUS);
  wire logic hit_mask = (avs_address_in == `DFA_OFF_MASK);
  wire logic hit_fbp = (avs_address_in == `DFA_OFF_FB_PTR);
  wire logic hit_cbp = (avs_address_in == `DFA_OFF_CB_PTR);
  wire logic hit_any = hit_vid || hit_pitch || hit_size || hit_rsvd || hit_ctrl ||
                       hit_status || hit_mask || hit_fbp || hit_cbp;

  // Byte lanes expanded to a bit mask
  wire logic [31:0] lane_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                                 {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // Merge write data into a register through lanes and field mask
  function automatic logic [31:0] dfa_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [31:0] lanes,
                                            input logic [31:0] fields);
    logic [31:0] m;
    m = lanes & fields;
    dfa_merge = (old_v & ~m) | (new_v & m);
  endfunction : dfa_merge

  // Field extraction
  wire logic [21:0] video_start_field = vid_r[`DFA_VID_MSB:0]; // see R1
  wire logic [9:0] compressed_line_pitch = pitch_r[`DFA_CB_PITCH_MSB:`DFA_CB_PITCH_LSB];
  wire logic [9:0] frame_line_pitch = pitch_r[`DFA_FB_PITCH_MSB:0];
  wire logic [13:0] video_buffer_size_field = size_r[`DFA_VSIZE_MSB:`DFA_VSIZE_LSB];
  wire logic [CB_LEN_W-1:0] compressed_line_length = size_r[`DFA_CB_LEN_MSB:`DFA_CB_LEN_LSB];
  wire logic [QW_W-1:0] frame_line_fetch_length = size_r[`DFA_FB_FETCH_MSB:0];
  wire logic fetch_en = ctrl_r[0];

  // Running pointers, read back by software
  wire logic [21:0] fb_ptr;
  wire logic [21:0] cb_ptr;

  // Read mux; reserved word and holes read as zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit_vid)
      rdata_nxt = vid_r;
    else if (hit_pitch)
      rdata_nxt = pitch_r;
    else if (hit_size)
      rdata_nxt = size_r;
    else if (hit_ctrl)
      rdata_nxt = ctrl_r;
    else if (hit_status)
      rdata_nxt = status_r;
    else if (hit_mask)
      rdata_nxt = mask_r;
    else if (hit_fbp)
      rdata_nxt = {10'h000, fb_ptr};
    else if (hit_cbp)
      rdata_nxt = {10'h000, cb_ptr};
  end

  // Handshake and read data
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wait_r <= wait_nxt;
      if (rd_sample)
        rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  // Low four start bits and reserved bits are not stored
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      vid_r <= `DFA_RST_REG;
      pitch_r <= `DFA_RST_REG;
      size_r <= `DFA_RST_REG;
      ctrl_r <= `DFA_RST_REG;
      mask_r <= `DFA_RST_REG;
    end
    else if (wr_take)
    begin
      if (hit_vid)
        vid_r <= dfa_merge(vid_r, avs_writedata_in, lane_mask, `DFA_MASK_VID); // see R2
      if (hit_pitch)
        pitch_r <= dfa_merge(pitch_r, avs_writedata_in, lane_mask, `DFA_MASK_PITCH);
      if (hit_size)
        size_r <= dfa_merge(size_r, avs_writedata_in, lane_mask, `DFA_MASK_SIZE);
      if (hit_ctrl)
        ctrl_r <= dfa_merge(ctrl_r, avs_writedata_in, lane_mask, `DFA_MASK_CTRL);
      if (hit_mask)
        mask_r <= dfa_merge(mask_r, avs_writedata_in, lane_mask, `DFA_MASK_EVT);
    end
  end

  // ****************************************************************
  // Line pointers
  // ****************************************************************

  // Frame start wins over a line start in the same cycle
  wire logic line_go = line_start_in && !frame_start_in;

  dfa_line_ptr #(
    .PTR_W(22),
    .PITCH_W(10)
  ) u_fb_ptr (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .reload_in(frame_start_in),
    .step_in(line_go),
    .start_in(fb_start_in),
    .pitch_in(frame_line_pitch),
    .ptr_out(fb_ptr)
  );

  dfa_line_ptr #(
    .PTR_W(22),
    .PITCH_W(10)
  ) u_cb_ptr (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .reload_in(frame_start_in),
    .step_in(line_go),
    .start_in(cb_start_in),
    .pitch_in(compressed_line_pitch),
    .ptr_out(cb_ptr)
  );

  // ****************************************************************
  // Frame buffer fetch
  // ****************************************************************

  // Line fetch starts at base plus the current frame pointer
  wire logic [31:0] fb_line_addr = graphics_memory_base_in + {10'h000, fb_ptr};
  wire logic fetch_done;
  wire logic fetch_discard;

  dfa_fetch_ctl #(
    .QW_W(QW_W)
  ) u_fetch (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .go_in(line_go && fetch_en),
    .line_addr_in(fb_line_addr),
    .qw_count_in(frame_line_fetch_length), // see R8
    .line_end_in(line_start_in || frame_start_in), // see R10
    .qw_used_in(qw_used_in),
    .mem_rsp_in(mem_rsp_in),
    .mem_req_out(mem_req_out),
    .done_out(fetch_done),
    .discard_out(fetch_discard)
  );

  // ****************************************************************
  // Compressed FIFO overflow and buffer addresses
  // ****************************************************************

  logic [CB_LEN_W:0] cb_cnt_r;
  logic cb_ovf_r;
  logic [31:0] vid_addr_r;
  logic [31:0] vid_limit_r;
  logic [31:0] cb_addr_r;

  // Field holds length plus one, so reaching it means one word too many
  wire logic [CB_LEN_W:0] cb_cnt_nxt = cb_cnt_r + (CB_LEN_W+1)'(1);
  wire logic cb_ovf_hit = cb_word_in && !line_start_in &&
                          (cb_cnt_nxt == {1'b0, compressed_line_length}); // see R6

  // Size in 64-byte segments, clipped to the one megabyte ceiling
  wire logic [22:0] vid_bytes_raw = {3'b000, video_buffer_size_field, 6'h00}; // see R5
  wire logic [22:0] vid_bytes = (vid_bytes_raw > `DFA_VID_MAX_BYTES) ?
                                `DFA_VID_MAX_BYTES : vid_bytes_raw; // see R5

  // Absolute addresses for the memory side
  wire logic [31:0] vid_addr_nxt = graphics_memory_base_in + {10'h000, video_start_field}; // see R1
  wire logic [31:0] vid_limit_nxt = vid_addr_nxt + {9'h000, vid_bytes};
  wire logic [31:0] cb_addr_nxt = graphics_memory_base_in + {10'h000, cb_ptr}; // see R3

  // Word count restarts with each line; overflow flag stands to line end
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cb_cnt_r <= '0;
      cb_ovf_r <= 1'b0;
    end
    else if (line_start_in || frame_start_in)
    begin
      cb_cnt_r <= '0;
      cb_ovf_r <= 1'b0;
    end
    else if (cb_word_in)
    begin
      if (!cb_cnt_r[CB_LEN_W])
        cb_cnt_r <= cb_cnt_nxt;
      if (cb_ovf_hit)
        cb_ovf_r <= 1'b1;
    end
  end

  // Registered copies so every output except mem_req_out.req leaves a flop
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      vid_addr_r <= 32'h0000_0000;
      vid_limit_r <= 32'h0000_0000;
      cb_addr_r <= 32'h0000_0000;
    end
    else
    begin
      vid_addr_r <= vid_addr_nxt;
      vid_limit_r <= vid_limit_nxt;
      cb_addr_r <= cb_addr_nxt;
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************

  logic irq_r;

  // Event vector in status bit order
  wire logic [31:0] evt_set = {27'h000_0000,
                               req && wait_r && !hit_any,
                               fetch_discard,
                               cb_ovf_hit,
                               fetch_done,
                               frame_start_in};

  // Write one clears; a new event in the same cycle wins
  wire logic [31:0] w1c = (wr_take && hit_status) ?
                          (avs_writedata_in & lane_mask & `DFA_MASK_EVT) : 32'h0000_0000;
  assign status_nxt = (status_r & ~w1c) | evt_set;

  // Status and interrupt line
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      status_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign vid_addr_out = vid_addr_r;
  assign vid_limit_out = vid_limit_r;
  assign cb_line_addr_out = cb_addr_r;
  assign cb_overflow_out = cb_ovf_r;
  assign irq_out = irq_r;

endmodule : dfa_top
